// ### shared/cmbf_pkg.sv
`default_nettype none
// ==================================================
// Shared constants for the connection memory block fill
package cmbf_pkg;
    // ==================================================
    // Register map and bus widths
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;
    localparam logic [3:0] REG_SWITCH_CONTROL = 4'h0;
    localparam logic [3:0] REG_FILL_STATUS = 4'h1;
    localparam logic [15:0] SWITCH_CONTROL_RESET = 16'h0000;

    // ==================================================
    // Field positions in switch_control
    localparam int ARM_BIT = 9;
    localparam int VALUE_LSB = 5;
    localparam int VALUE_W = 4;
    localparam int GO_BIT = 4;

    // Field positions in fill_status
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WAIT_BIT = 1;
    localparam int STAT_ABORT_BIT = 2;

    // ==================================================
    // Connection memory shape
    localparam int CM_DEPTH = 1024;
    localparam int CM_AW = 10;
    localparam int CM_DW = 16;
    localparam int CM_FILL_LSB = 12;

    // ==================================================
    // Frame timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int FRAME_PERIOD_NS = 125000;
    localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FILL_FRAMES = 2;

    // ==================================================
    // Fill sequencer states
    typedef enum logic [1:0] {
        FILL_IDLE,
        FILL_WAIT,
        FILL_FRAME1,
        FILL_FRAME2
    } cmbf_state_t;
endpackage
`default_nettype wire

// ### shared/cmbf_walk_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Link between the fill sequencer and the address walker
interface cmbf_walk_if #(
    parameter int AW = 10
);
    logic start;
    logic abort;
    logic we;
    logic [AW-1:0] addr;

    modport ctrl (
        output start,
        output abort,
        input we,
        input addr
    );
    modport walker (
        input start,
        input abort,
        output we,
        output addr
    );
endinterface
`default_nettype wire

// ### src/cmbf_frame_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Free running frame timer, one tick per frame
module cmbf_frame_timer #(
    parameter int FRAME_CYCLES = cmbf_pkg::FRAME_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    output logic o_frame_tick
);
    localparam int CW = $clog2(FRAME_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(FRAME_CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    // Wrap at the frame length; tick marks the last cycle of each frame
    always_comb begin
        cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        tick_d = (cnt_d == LAST);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign o_frame_tick = tick_q;
endmodule
`default_nettype wire

// ### src/cmbf_addr_walker.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Steps through every connection memory word, one per cycle
module cmbf_addr_walker #(
    parameter int DEPTH = cmbf_pkg::CM_DEPTH,
    parameter int AW = cmbf_pkg::CM_AW
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    cmbf_walk_if.walker walk
);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic we_q;
    logic we_d;
    logic [AW-1:0] addr_q;
    logic [AW-1:0] addr_d;

    // Abort wins over start so a cancelled fill never writes again
    always_comb begin
        we_d = we_q;
        addr_d = addr_q;
        if (walk.abort) begin
            we_d = 1'b0;
        end else if (walk.start) begin
            we_d = 1'b1;
            addr_d = '0;
        end else if (we_q) begin
            if (addr_q == LAST) begin
                we_d = 1'b0;
            end else begin
                addr_d = addr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            we_q <= 1'b0;
            addr_q <= '0;
        end else begin
            we_q <= we_d;
            addr_q <= addr_d;
        end
    end

    assign walk.we = we_q;
    assign walk.addr = addr_q;
endmodule
`default_nettype wire

// ### src/cmbf_block_fill.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
module cmbf_block_fill #(
    parameter int FRAME_CYCLES = cmbf_pkg::FRAME_CYCLES,
    parameter int CM_DEPTH = cmbf_pkg::CM_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [cmbf_pkg::REG_AW-1:0] i_addr,
    input wire logic [cmbf_pkg::REG_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [cmbf_pkg::REG_DW-1:0] o_rdata,
    output logic o_cm_we,
    output logic [cmbf_pkg::CM_AW-1:0] o_cm_addr,
    output logic [cmbf_pkg::CM_DW-1:0] o_cm_wdata,
    output logic o_fill_busy
);
    localparam int VW = cmbf_pkg::VALUE_W;
    localparam int FILL_TOTAL = cmbf_pkg::FILL_FRAMES * FRAME_CYCLES;
    localparam int FILL_LAST = FILL_TOTAL - 1;

    // ==================================================
    // Field packing helpers

    // Readback image of switch_control; unused bits read zero
    function automatic logic [cmbf_pkg::REG_DW-1:0] ctrl_word(
        input logic arm,
        input logic [VW-1:0] val,
        input logic go
    );
        logic [cmbf_pkg::REG_DW-1:0] w;
        w = '0;
        w[cmbf_pkg::ARM_BIT] = arm;
        w[cmbf_pkg::VALUE_LSB +: VW] = val;
        w[cmbf_pkg::GO_BIT] = go;
        return w;
    endfunction

    // Word written into every connection memory location
    function automatic logic [cmbf_pkg::CM_DW-1:0] fill_word(input logic [VW-1:0] val);
        logic [cmbf_pkg::CM_DW-1:0] w;
        w = '0;
        w[cmbf_pkg::CM_FILL_LSB +: VW] = val;
        return w;
    endfunction

    // ==================================================
    // Frame timer and address walker

    logic frame_tick;
    cmbf_walk_if #(.AW(cmbf_pkg::CM_AW)) walk ();

    cmbf_frame_timer #(
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_frame_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .o_frame_tick(frame_tick)
    );

    cmbf_addr_walker #(
        .DEPTH(CM_DEPTH),
        .AW(cmbf_pkg::CM_AW)
    ) u_addr_walker (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .walk(walk.walker)
    );

    // ==================================================
    // Bus decode

    logic ctrl_hit;
    logic stat_hit;
    logic ctrl_wr;
    logic new_go;
    logic new_arm;
    logic start_fill;
    logic abort_req;
    logic fill_done;

    logic arm_q;
    logic arm_d;
    logic go_q;
    logic go_d;
    logic [VW-1:0] val_q;
    logic [VW-1:0] val_d;
    logic aborted_q;
    logic aborted_d;
    cmbf_pkg::cmbf_state_t state_q;
    cmbf_pkg::cmbf_state_t state_d;

    // Start and abort are judged from the single write, since arm and go arrive together
    always_comb begin
        ctrl_hit = (i_addr == cmbf_pkg::REG_SWITCH_CONTROL);
        stat_hit = (i_addr == cmbf_pkg::REG_FILL_STATUS);
        ctrl_wr = i_wr && ctrl_hit;
        new_go = i_wdata[cmbf_pkg::GO_BIT];
        new_arm = i_wdata[cmbf_pkg::ARM_BIT];
        start_fill = ctrl_wr && new_go && !go_q && new_arm;
        abort_req = ctrl_wr && (state_q != cmbf_pkg::FILL_IDLE) && (!new_go || !new_arm);
        fill_done = (state_q == cmbf_pkg::FILL_FRAME2) && frame_tick;
    end

    // ==================================================
    // Control register

    // A software write beats the self clear, so a go set in the done cycle survives
    always_comb begin
        arm_d = arm_q;
        val_d = val_q;
        go_d = go_q;
        aborted_d = aborted_q;
        if (ctrl_wr) begin
            arm_d = new_arm;
            val_d = i_wdata[cmbf_pkg::VALUE_LSB +: VW];
            go_d = new_go;
        end else if (fill_done) begin
            go_d = 1'b0;
        end
        if (abort_req) begin
            aborted_d = 1'b1;
        end else if (start_fill) begin
            aborted_d = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            arm_q <= cmbf_pkg::SWITCH_CONTROL_RESET[cmbf_pkg::ARM_BIT];
            val_q <= cmbf_pkg::SWITCH_CONTROL_RESET[cmbf_pkg::VALUE_LSB +: VW];
            go_q <= cmbf_pkg::SWITCH_CONTROL_RESET[cmbf_pkg::GO_BIT];
            aborted_q <= 1'b0;
        end else begin
            arm_q <= arm_d;
            val_q <= val_d;
            go_q <= go_d;
            aborted_q <= aborted_d;
        end
    end

    // ==================================================
    // Fill sequencer

    // The walk runs in the first frame; the second frame pads out the documented fill time
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            cmbf_pkg::FILL_IDLE: begin
                if (start_fill) begin
                    state_d = cmbf_pkg::FILL_WAIT;
                end
            end
            cmbf_pkg::FILL_WAIT: begin
                if (frame_tick) begin
                    state_d = cmbf_pkg::FILL_FRAME1;
                end
            end
            cmbf_pkg::FILL_FRAME1: begin
                if (frame_tick) begin
                    state_d = cmbf_pkg::FILL_FRAME2;
                end
            end
            cmbf_pkg::FILL_FRAME2: begin
                if (frame_tick) begin
                    state_d = cmbf_pkg::FILL_IDLE;
                end
            end
        endcase
        if (abort_req) begin
            state_d = cmbf_pkg::FILL_IDLE;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q <= cmbf_pkg::FILL_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Walker starts on the frame boundary so the whole memory is covered in one frame
    assign walk.start = (state_q == cmbf_pkg::FILL_WAIT) && frame_tick && !abort_req;
    assign walk.abort = abort_req;

    // ==================================================
    // Output registers

    logic [cmbf_pkg::REG_DW-1:0] rdata_q;
    logic [cmbf_pkg::REG_DW-1:0] rdata_d;
    logic [cmbf_pkg::CM_DW-1:0] cm_wdata_q;
    logic [cmbf_pkg::CM_DW-1:0] cm_wdata_d;
    logic busy_q;
    logic busy_d;

    // Read data are valid only in the cycle after the strobe; unmapped offsets read zero
    always_comb begin
        rdata_d = '0;
        if (i_rd && ctrl_hit) begin
            rdata_d = ctrl_word(arm_q, val_q, go_q);
        end else if (i_rd && stat_hit) begin
            rdata_d[cmbf_pkg::STAT_BUSY_BIT] = busy_q;
            rdata_d[cmbf_pkg::STAT_WAIT_BIT] = (state_q == cmbf_pkg::FILL_WAIT);
            rdata_d[cmbf_pkg::STAT_ABORT_BIT] = aborted_q;
        end
        cm_wdata_d = fill_word(val_q);
        busy_d = (state_d != cmbf_pkg::FILL_IDLE);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata_q <= '0;
            cm_wdata_q <= '0;
            busy_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            cm_wdata_q <= cm_wdata_d;
            busy_q <= busy_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_cm_we = walk.we;
    assign o_cm_addr = walk.addr;
    assign o_cm_wdata = cm_wdata_q;
    assign o_fill_busy = busy_q;

    // ==================================================
    // Assertion helpers

    // Cycles spent in the two fill frames, checked against the fill length
    logic [15:0] fill_cnt_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || state_q == cmbf_pkg::FILL_WAIT) begin
            fill_cnt_q <= '0;
        end else if (state_q != cmbf_pkg::FILL_IDLE) begin
            fill_cnt_q <= fill_cnt_q + 16'h0001;
        end
    end

    sequence s_go_rise;
        ctrl_wr && new_go && new_arm && !go_q && state_q == cmbf_pkg::FILL_IDLE;
    endsequence

    sequence s_idle_quiet;
        state_q == cmbf_pkg::FILL_IDLE && !o_cm_we;
    endsequence

    a_fill_start_cause: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (state_q == cmbf_pkg::FILL_WAIT && $past(state_q) == cmbf_pkg::FILL_IDLE)
            |-> $past(ctrl_wr && new_go && new_arm && !go_q))
        else $error("fill started without a go rise while armed");

    a_go_held_quiet: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (ctrl_wr && go_q && state_q == cmbf_pkg::FILL_IDLE) |=> state_q == cmbf_pkg::FILL_IDLE)
        else $error("held go bit started a new fill");

    a_go_rise_starts: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        s_go_rise |=> state_q == cmbf_pkg::FILL_WAIT && o_fill_busy)
        else $error("armed go rise did not start a fill");

    a_fill_upper_value: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_cm_we |-> o_cm_wdata[cmbf_pkg::CM_FILL_LSB +: VW] == val_q)
        else $error("fill word upper bits differ from fill value");

    a_fill_lower_zero: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_cm_we |-> o_cm_wdata[cmbf_pkg::CM_FILL_LSB-1:0] == '0)
        else $error("fill word lower bits not zero");

    a_fill_two_frames: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        fill_done |-> fill_cnt_q == 16'(FILL_LAST))
        else $error("fill did not last two frames");

    a_done_clears_go: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (fill_done && !ctrl_wr) |=> !go_q ##0 s_idle_quiet)
        else $error("go bit not cleared after fill");

    a_abort_stops_fill: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        abort_req |=> s_idle_quiet ##1 (!o_cm_we)[*2])
        else $error("abort did not stop the fill");

    a_reset_ctrl_zero: assert property (
        @(posedge i_sys_clk)
        $past(i_rst) |-> (!arm_q && !go_q && val_q == '0 && !o_fill_busy))
        else $error("control register not zero after reset");
endmodule
`default_nettype wire

// ### dv/test_connection_memory_block_fill.sv
`timescale 1ns/1ps
`default_nettype none
module test_connection_memory_block_fill;
    // ==================================================
    // Short frames keep the run small; the frame must still outlast the walk
    localparam int F = 32;
    localparam int D = 16;
    localparam logic [3:0] CTRL = cmbf_pkg::REG_SWITCH_CONTROL;
    localparam logic [3:0] STAT = cmbf_pkg::REG_FILL_STATUS;

    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [cmbf_pkg::REG_AW-1:0] i_addr = 4'h0;
    logic [cmbf_pkg::REG_DW-1:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [cmbf_pkg::REG_DW-1:0] o_rdata;
    logic o_cm_we;
    logic [cmbf_pkg::CM_AW-1:0] o_cm_addr;
    logic [cmbf_pkg::CM_DW-1:0] o_cm_wdata;
    logic o_fill_busy;
    int fails = 0;
    int comparisons = 0;
    logic [15:0] r;
    logic [3:0] v;
    int seed_dummy;

    cmbf_block_fill #(.FRAME_CYCLES(F), .CM_DEPTH(D)) dut (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .o_cm_we(o_cm_we),
        .o_cm_addr(o_cm_addr),
        .o_cm_wdata(o_cm_wdata),
        .o_fill_busy(o_fill_busy)
    );

    // ==================================================
    // Clock, 100 ns period
    always #50 i_sys_clk = ~i_sys_clk;

    // ==================================================
    // Expectation helpers
    function automatic logic [15:0] ctrl_word(input logic arm, input logic [3:0] val, input logic go);
        return (16'(arm) << cmbf_pkg::ARM_BIT) | (16'(val) << cmbf_pkg::VALUE_LSB) | (16'(go) << cmbf_pkg::GO_BIT);
    endfunction

    function automatic logic [15:0] fill_word(input logic [3:0] val);
        return {val, 12'h000};
    endfunction

    // ==================================================
    // Comparisons
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: flag got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("Counts: comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==================================================
    // Register bus master; every task returns 1 ns after its last edge
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    // Bounded wait for the walk to begin; the fill waits for a frame boundary
    task automatic wait_we;
        int n;
        n = 0;
        while (o_cm_we !== 1'b1 && n < 2 * F) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        chk_flag(o_cm_we, 1'b1);
    endtask

    // ==================================================
    // Full fill: walk content, length, and self clear of go
    task automatic run_fill(input logic [3:0] val);
        int n;
        int span;
        logic [15:0] rv;
        wr_reg(CTRL, 16'h0000);
        wr_reg(CTRL, ctrl_word(1'b1, val, 1'b1));
        chk_flag(o_fill_busy, 1'b1);
        wait_we();
        n = 0;
        while (o_cm_we === 1'b1 && n < 2 * D) begin
            chk_val(16'(o_cm_addr), 16'(n));
            chk_val(o_cm_wdata, fill_word(val));
            n++;
            @(posedge i_sys_clk);
            #1;
        end
        chk_val(16'(n), 16'(D));
        span = n;
        // Go still reads 1 mid-fill, before the second boundary; only reads while go is 1
        rd_reg(CTRL, rv);
        span += 2;
        chk_val(rv, ctrl_word(1'b1, val, 1'b1));
        while (o_fill_busy === 1'b1 && span < 3 * F) begin
            @(posedge i_sys_clk);
            #1;
            span++;
        end
        chk_val(16'(span), 16'(2 * F));
        rd_reg(CTRL, rv);
        chk_val(rv, ctrl_word(1'b1, val, 1'b0));
        $display("fill test value %h done", val);
    endtask

    // ==================================================
    // Abort mid-walk, then make sure nothing is written afterwards
    task automatic abort_fill(input logic [3:0] val, input logic [15:0] kill);
        int n;
        int seen;
        logic [15:0] rv;
        wr_reg(CTRL, 16'h0000);
        wr_reg(CTRL, ctrl_word(1'b1, val, 1'b1));
        wait_we();
        repeat (3) @(posedge i_sys_clk);
        wr_reg(CTRL, kill);
        chk_flag(o_fill_busy, 1'b0);
        chk_flag(o_cm_we, 1'b0);
        rd_reg(STAT, rv);
        chk_val(rv, 16'h0004);
        seen = 0;
        for (n = 0; n < 3 * F; n++) begin
            @(posedge i_sys_clk);
            #1;
            if (o_cm_we !== 1'b0) begin
                seen++;
            end
        end
        chk_val(16'(seen), 16'h0000);
        $display("abort test kill %h done", kill);
    endtask

    // ==================================================
    // Watchdog, sized well above the sum of all tests
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fails++;
        $display("MISMATCH at %0t: watchdog got %h expected %h", $time, 16'h0001, 16'h0000);
        end_of_test();
    end

    // ==================================================
    // Main sequence
    initial begin
        int n;
        int seen;
        seed_dummy = $urandom(32'hf3e48876);
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        #1;
        // Reset state and register map corners
        chk_flag(o_fill_busy, 1'b0);
        rd_reg(CTRL, r);
        chk_val(r, cmbf_pkg::SWITCH_CONTROL_RESET);
        rd_reg(STAT, r);
        chk_val(r, 16'h0000);
        wr_reg(4'h5, 16'hffff);
        rd_reg(4'h5, r);
        chk_val(r, 16'h0000);
        wr_reg(STAT, 16'hffff);
        rd_reg(STAT, r);
        chk_val(r, 16'h0000);
        // Unused low bits stay zero; the standby and evaluation bits are not stored
        wr_reg(CTRL, 16'h000c);
        rd_reg(CTRL, r);
        chk_val(r, 16'h0000);
        $display("register map test done");
        // Go without arm must not start anything
        wr_reg(CTRL, ctrl_word(1'b0, 4'h5, 1'b1));
        chk_flag(o_fill_busy, 1'b0);
        seen = 0;
        for (n = 0; n < 3 * F; n++) begin
            @(posedge i_sys_clk);
            #1;
            if (o_cm_we !== 1'b0) begin
                seen++;
            end
        end
        chk_val(16'(seen), 16'h0000);
        $display("unarmed go test done");
        // Corner values, then random ones
        run_fill(4'h0);
        run_fill(4'hf);
        for (n = 0; n < 3; n++) begin
            v = 4'($urandom());
            run_fill(v);
        end
        v = 4'($urandom());
        abort_fill(v, ctrl_word(1'b1, v, 1'b0));
        v = 4'($urandom());
        abort_fill(v, ctrl_word(1'b0, v, 1'b1));
        // Go left at 1 by the disarming abort: arming it again with go still 1 is no rise
        wr_reg(CTRL, ctrl_word(1'b1, v, 1'b1));
        chk_flag(o_fill_busy, 1'b0);
        $display("held go test done");
        // A fresh start after an abort still runs in full
        run_fill(4'ha);
        end_of_test();
    end
endmodule
`default_nettype wire
